// ### rtl/dsw_decoder.sv
// Data-space address decoder for an 8-bit core: bank pages, program window,
// general RAM and peripheral area. Assumes the core holds address and data stable
// for one strobed cycle; program memory answers with a one-cycle read latency.
`timescale 1ns/1ps
module dsw_decoder #(
  parameter int GRAM_SIZE = dsw_pkg::GRAM_BYTES,
  parameter int STACK_LEVELS = dsw_pkg::STACK_DEPTH
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [7:0] dataAddr,
  input wire logic dataRd,
  input wire logic dataWr,
  input wire logic [7:0] dataWrData,
  output logic [7:0] dataRdData,
  input wire logic stackPush,
  input wire logic stackPop,
  input wire logic [11:0] stackPushAddr,
  output logic [11:0] stackTop,
  output logic [11:0] progAddr,
  output logic progRd,
  input wire logic [7:0] progData,
  output logic [5:0] bankAddr,
  output logic bankRd,
  output logic bankWr,
  output logic [7:0] bankWrData,
  input wire logic [7:0] bankRdData,
  output logic ramPage2Select,
  output logic eepromPage1Select,
  output logic eepromPage0Select,
  output logic [7:0] periphAddr,
  output logic periphRd,
  output logic periphWr,
  output logic [7:0] periphWrData,
  input wire logic [7:0] periphRdData
);
  dsw_pkg::dsw_target_t target;
  dsw_pkg::dsw_target_t rdTarget;
  dsw_pkg::dsw_target_t next_rdTarget;
  logic [5:0] windowUpperAddressBits;
  logic [5:0] next_windowUpperAddressBits;
  logic [7:0] pageBankSelect;
  logic [7:0] next_pageBankSelect;
  logic [7:0] gram [GRAM_SIZE];
  logic [7:0] gramRd;
  logic [7:0] next_gramRd;
  logic [11:0] stack [STACK_LEVELS];
  logic [11:0] next_stack [STACK_LEVELS];
  logic [5:0] gramIdx;
  logic winBaseWr;
  logic bankSelWr;

  // Address decode; the two write-only registers live inside the peripheral area
  always_comb
  begin
    if (dataAddr <= dsw_pkg::BANK_HI)
      target = dsw_pkg::TGT_BANK;
    else if (dataAddr >= dsw_pkg::WIN_LO && dataAddr <= dsw_pkg::WIN_HI)
      target = dsw_pkg::TGT_WIN;
    else if (dataAddr >= dsw_pkg::GRAM_LO && dataAddr <= dsw_pkg::GRAM_HI)
      target = dsw_pkg::TGT_GRAM;
    else if (dataAddr >= dsw_pkg::PERIPH_LO)
      target = dsw_pkg::TGT_PERIPH;
    else
      target = dsw_pkg::TGT_NONE;
  end

  assign winBaseWr = dataWr && (dataAddr == dsw_pkg::PROGRAM_WINDOW_BASE_ADDR);
  assign bankSelWr = dataWr && (dataAddr == dsw_pkg::PAGE_BANK_SELECT_ADDR);
  assign gramIdx = 6'(dataAddr - dsw_pkg::GRAM_LO);

  // Window: program address formed combinationally so memory answers next cycle
  assign progAddr = {windowUpperAddressBits, dataAddr[5:0]};
  assign progRd = dataRd && (target == dsw_pkg::TGT_WIN);

  // Bank region passes straight to the paged memories; page is chosen by bank select
  assign bankAddr = dataAddr[5:0];
  assign bankRd = dataRd && (target == dsw_pkg::TGT_BANK);
  assign bankWr = dataWr && (target == dsw_pkg::TGT_BANK);
  assign bankWrData = dataWrData;
  assign ramPage2Select = pageBankSelect[dsw_pkg::RAM_PAGE2_BIT];
  assign eepromPage1Select = pageBankSelect[dsw_pkg::EEPROM_PAGE1_BIT];
  assign eepromPage0Select = pageBankSelect[dsw_pkg::EEPROM_PAGE0_BIT];

  // The write-only registers are kept off the peripheral strobes so nothing echoes them
  assign periphAddr = dataAddr;
  assign periphRd = dataRd && (target == dsw_pkg::TGT_PERIPH)
    && dataAddr != dsw_pkg::PROGRAM_WINDOW_BASE_ADDR
    && dataAddr != dsw_pkg::PAGE_BANK_SELECT_ADDR;
  assign periphWr = dataWr && (target == dsw_pkg::TGT_PERIPH) && !winBaseWr && !bankSelWr;
  assign periphWrData = dataWrData;

  // Configuration registers: no reset clears them, only software writes
  always_comb
  begin
    next_windowUpperAddressBits = windowUpperAddressBits;
    next_pageBankSelect = pageBankSelect;
    if (winBaseWr)
      next_windowUpperAddressBits = dataWrData[dsw_pkg::WIN_BASE_BITS-1:0];
    if (bankSelWr)
      next_pageBankSelect = dataWrData;
  end

  // Kept out of the reset network on purpose: reset must not disturb software's setting
  always_ff @(posedge sys_clk)
  begin
    if (clkEn)
    begin
      windowUpperAddressBits <= next_windowUpperAddressBits;
      pageBankSelect <= next_pageBankSelect;
    end
  end

  // Read return path: remember the target so the answer is muxed a cycle later
  always_comb
  begin
    next_rdTarget = rdTarget;
    next_gramRd = gramRd;
    if (dataRd)
    begin
      next_rdTarget = target;
      if (dataAddr == dsw_pkg::PROGRAM_WINDOW_BASE_ADDR
          || dataAddr == dsw_pkg::PAGE_BANK_SELECT_ADDR)
        next_rdTarget = dsw_pkg::TGT_NONE;
      if (target == dsw_pkg::TGT_GRAM)
        next_gramRd = gram[gramIdx];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdTarget <= dsw_pkg::TGT_NONE;
      gramRd <= 8'h00;
    end
    else if (clkEn)
    begin
      rdTarget <= next_rdTarget;
      gramRd <= next_gramRd;
    end
  end

  always_comb
  begin
    case (rdTarget)
      dsw_pkg::TGT_WIN: dataRdData = progData;
      dsw_pkg::TGT_BANK: dataRdData = bankRdData;
      dsw_pkg::TGT_GRAM: dataRdData = gramRd;
      dsw_pkg::TGT_PERIPH: dataRdData = periphRdData;
      default: dataRdData = 8'h00;
    endcase
  end

  // General RAM; a write to the window area raises no write strobe and so does nothing
  always_ff @(posedge sys_clk)
  begin
    if (clkEn && dataWr && target == dsw_pkg::TGT_GRAM)
      gram[gramIdx] <= dataWrData;
  end

  // Return stack: shift register, top at index 0; overflow drops the oldest
  always_comb
  begin
    for (int i = 0; i < STACK_LEVELS; i++)
      next_stack[i] = stack[i];
    if (stackPush)
    begin
      next_stack[0] = stackPushAddr;
      for (int i = 1; i < STACK_LEVELS; i++)
        next_stack[i] = stack[i-1];
    end
    else if (stackPop)
    begin
      for (int i = 0; i < STACK_LEVELS - 1; i++)
        next_stack[i] = stack[i+1];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < STACK_LEVELS; i++)
        stack[i] <= 12'h000;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < STACK_LEVELS; i++)
        stack[i] <= next_stack[i];
    end
  end

  assign stackTop = stack[0];
endmodule : dsw_decoder

// ### rtl/dsw_pkg.sv
// Package for the data-space window decoder: address map, field positions, widths.
// Assumes an 8-bit core data bus and a 12-bit program memory address.
package dsw_pkg;
  localparam logic [7:0] BANK_LO = 8'h00;
  localparam logic [7:0] BANK_HI = 8'h3F;
  localparam logic [7:0] WIN_LO = 8'h40;
  localparam logic [7:0] WIN_HI = 8'h7F;
  localparam logic [7:0] GRAM_LO = 8'h84;
  localparam logic [7:0] GRAM_HI = 8'hBF;
  localparam logic [7:0] PERIPH_LO = 8'hC0;
  localparam logic [7:0] PROGRAM_WINDOW_BASE_ADDR = 8'hC9;
  localparam logic [7:0] PAGE_BANK_SELECT_ADDR = 8'hE8;
  localparam int WIN_OFFSET_BITS = 6;
  localparam int WIN_BASE_BITS = 6;
  localparam int PROG_ADDR_BITS = 12;
  localparam int RAM_PAGE2_BIT = 4;
  localparam int EEPROM_PAGE1_BIT = 1;
  localparam int EEPROM_PAGE0_BIT = 0;
  localparam int GRAM_BYTES = 60;
  localparam int BANK_BYTES = 64;
  localparam int STACK_DEPTH = 6;
  // Window and bank registers are not cleared by reset; the decoder never loads this value
  // into them, and it carries no meaning for software.
  localparam logic [5:0] WIN_BASE_POWERUP = 6'h00;
  localparam logic [7:0] BANK_SEL_POWERUP = 8'h00;
  typedef enum logic [4:0] {
    TGT_BANK = 5'h01,
    TGT_WIN = 5'h02,
    TGT_GRAM = 5'h04,
    TGT_PERIPH = 5'h08,
    TGT_NONE = 5'h10
  } dsw_target_t;
endpackage : dsw_pkg

// ### verif/data_space_window_decoder_tb_top.sv
// Self-checking bench for the data-space window decoder.
// Assumes the memory model beside it; reads are checked a cycle after they are taken.
`timescale 1ns/1ps
module data_space_window_decoder_tb_top;
  logic sys_clk = 1'b0, arst_n = 1'b0, clkEn = 1'b1, dataRd = 1'b0, dataWr = 1'b0;
  logic stackPush = 1'b0, stackPop = 1'b0, pend = 1'b0;
  logic [7:0] dataAddr = 8'h00, dataWrData = 8'h00, b, o, g;
  logic [11:0] stackPushAddr = 12'h000, stackTop, progAddr;
  logic [7:0] dataRdData, progData, bankRdData, bankWrData, periphAddr, periphWrData, periphRdData;
  logic [5:0] bankAddr;
  logic progRd, bankRd, bankWr, periphRd, periphWr;
  logic ramPage2Select, eepromPage1Select, eepromPage0Select;
  logic [7:0] expQ[$];
  int err_count = 0;
  int cmp_count = 0;
  dsw_decoder u_dut (.*);
  dsw_mem_model u_mem (.*);
  always #20 sys_clk = ~sys_clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge sys_clk);
    dataWr <= w;
    dataRd <= !w;
    dataAddr <= a;
    dataWrData <= d;
    if (!w)
      expQ.push_back(e);
  endtask : acc
  task automatic idle();
    @(posedge sys_clk);
    dataWr <= 1'b0;
    dataRd <= 1'b0;
  endtask : idle
  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  always @(posedge sys_clk)
    pend <= clkEn && dataRd;
  always @(negedge sys_clk)
    if (pend)
      chk({4'h0, dataRdData}, {4'h0, expQ.pop_front()});
  initial
  begin
    repeat (500) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(62374));
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    // Base write then window read back to back, base extremes first
    for (int i = 0; i < 6; i++)
    begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      o = {2'b01, 6'($urandom)};
      acc(1'b1, 8'hC9, b, 8'h00);
      acc(1'b0, o, 8'h00, {b[1:0], o[5:0]} ^ {b[5:2], 4'hA});
    end
    acc(1'b1, o, 8'h33, 8'h00);
    acc(1'b0, o, 8'h00, {b[1:0], o[5:0]} ^ {b[5:2], 4'hA});
    // A base write while the enable is low must not move the window
    idle();
    clkEn <= 1'b0;
    acc(1'b1, 8'hC9, ~b, 8'h00);
    idle();
    clkEn <= 1'b1;
    acc(1'b0, o, 8'h00, {b[1:0], o[5:0]} ^ {b[5:2], 4'hA});
    acc(1'b0, 8'hC9, 8'h00, 8'h00);
    acc(1'b0, 8'hE8, 8'h00, 8'h00);
    g = 8'($urandom);
    acc(1'b1, 8'h84, g, 8'h00);
    acc(1'b1, 8'hBF, ~g, 8'h00);
    acc(1'b0, 8'h84, 8'h00, g);
    acc(1'b0, 8'hBF, 8'h00, ~g);
    acc(1'b0, 8'h83, 8'h00, 8'h00);
    acc(1'b0, 8'hD0, 8'h00, 8'hD0 ^ 8'h5A);
    for (int k = 0; k < 3; k++)
    begin
      g = (k == 0) ? 8'h10 : (k == 1) ? 8'h02 : 8'h01;
      acc(1'b1, 8'hE8, g, 8'h00);
      acc(1'b0, 8'h3F, 8'h00, 8'hBF);
      idle();
      @(negedge sys_clk);
      chk({9'h000, ramPage2Select, eepromPage1Select, eepromPage0Select}, {9'h000, g[4], g[1:0]});
    end
    @(posedge sys_clk);
    stackPush <= 1'b1;
    stackPushAddr <= 12'($urandom);
    @(posedge sys_clk);
    stackPush <= 1'b0;
    @(negedge sys_clk);
    chk(stackTop, stackPushAddr);
    @(posedge sys_clk);
    stackPop <= 1'b1;
    @(posedge sys_clk);
    stackPop <= 1'b0;
    @(negedge sys_clk);
    chk(stackTop, 12'h000);
    print_verdict();
  end
endmodule : data_space_window_decoder_tb_top

// ### verif/dsw_decoder_props.sv
// Checker for the data-space window decoder.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/1ps
module dsw_decoder_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [7:0] dataAddr,
  input wire logic dataRd,
  input wire logic dataWr,
  input wire logic [7:0] dataWrData,
  input wire logic [7:0] dataRdData,
  input wire logic [11:0] progAddr,
  input wire logic progRd,
  input wire logic bankRd,
  input wire logic bankWr,
  input wire logic periphRd,
  input wire logic periphWr,
  input wire logic ramPage2Select,
  input wire logic eepromPage1Select,
  input wire logic eepromPage0Select
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] lastWr;
  wire inWin = dataAddr[7:6] == 2'b01;
  wire rdOk = clkEn && dataRd;
  always_ff @(posedge sys_clk)
    lastWr <= dataWrData;
  property p_winRd; rdOk && inWin |-> progRd && !bankRd && !periphRd; endproperty
  a_winRd: assert property (p_winRd) else $error("window read misrouted");
  property p_winLow; progRd |-> progAddr[5:0] == dataAddr[5:0]; endproperty
  a_winLow: assert property (p_winLow) else $error("window offset wrong");
  property p_base; (clkEn && dataWr && dataAddr == 8'hC9) ##1 progRd
    |-> progAddr[11:6] == lastWr[5:0]; endproperty
  a_base: assert property (p_base) else $error("window base wrong");
  property p_noRd; rdOk && (dataAddr == 8'hC9 || dataAddr == 8'hE8) |=> dataRdData == 8'h00;
  endproperty
  a_noRd: assert property (p_noRd) else $error("write-only reg readable");
  property p_winWr; clkEn && dataWr && inWin |-> !bankWr && !periphWr; endproperty
  a_winWr: assert property (p_winWr) else $error("window write leaked");
  property p_woWr; dataWr && (dataAddr == 8'hC9 || dataAddr == 8'hE8) |-> !periphWr;
  endproperty
  a_woWr: assert property (p_woWr) else $error("write-only reg reached periphery");
  property p_bankWr; dataWr && dataAddr[7:6] == 2'b00 |-> bankWr && !periphWr; endproperty
  a_bankWr: assert property (p_bankWr) else $error("page write misrouted");
  property p_bank; rdOk && dataAddr[7:6] == 2'b00 |-> bankRd && !progRd; endproperty
  a_bank: assert property (p_bank) else $error("page read misrouted");
  property p_gram; rdOk && dataAddr inside {[8'h84:8'hBF]} |-> !(bankRd || progRd || periphRd);
  endproperty
  a_gram: assert property (p_gram) else $error("ram read misrouted");
  property p_sel; clkEn && dataWr && dataAddr == 8'hE8
    |=> {ramPage2Select, eepromPage1Select, eepromPage0Select} == {lastWr[4], lastWr[1:0]};
  endproperty
  a_sel: assert property (p_sel) else $error("page select wrong");
endmodule : dsw_decoder_props
bind dsw_decoder dsw_decoder_props u_props (.*);

// ### verif/dsw_mem_model.sv
// Program, page and peripheral memories answering one cycle after a strobe.
// Outside a read the data toggles, so stale data never matches by luck.
`timescale 1ns/1ps
module dsw_mem_model (
  input wire logic sys_clk,
  input wire logic [11:0] progAddr,
  input wire logic progRd,
  output logic [7:0] progData = 8'h00,
  input wire logic [5:0] bankAddr,
  input wire logic bankRd,
  output logic [7:0] bankRdData = 8'h00,
  input wire logic [7:0] periphAddr,
  input wire logic periphRd,
  output logic [7:0] periphRdData = 8'h00
);
  always @(posedge sys_clk)
  begin
    progData <= progRd ? progAddr[7:0] ^ {progAddr[11:8], 4'hA} : ~progData;
    bankRdData <= bankRd ? {2'b10, bankAddr} : ~bankRdData;
    periphRdData <= periphRd ? periphAddr ^ 8'h5A : ~periphRdData;
  end
endmodule : dsw_mem_model
